// ==== design/ptc_target.sv ====
// Interrupt target: enables, threshold, vector base, handler pointer, capture
module ptc_target
	import ptc_pkg::*;
#(
	parameter int NSRC = PTC_NSRC,
	parameter bit FAST_REDIRECT = 1'b0
)
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// CSR port from the core
	input wire logic [11:0] i_csr_addr,
	input wire logic i_csr_wr,
	input wire logic i_csr_rd,
	input wire logic [31:0] i_csr_wdata,
	output logic o_csr_hit,
	output logic [31:0] o_csr_rdata,
	// Memory-mapped port, byte offset inside the window
	input wire logic [14:0] i_mm_addr,
	input wire logic i_mm_wr,
	input wire logic i_mm_rd,
	input wire logic [31:0] i_mm_wdata,
	output logic [31:0] o_mm_rdata,
	// Source state from gateways and level storage, standard-order levels
	input wire logic [NSRC:0] i_src_pending,
	input wire logic [(NSRC+1)*PTC_PRIO_W-1:0] i_src_prio,
	// Hardware capture start for fast redirect builds
	input wire logic i_hw_capture,
	// Outputs toward the core and the rest of the controller
	output logic o_ext_int,
	output logic o_prio_reversed,
	output logic [NSRC:0] o_src_enable
);
	logic [NSRC:0] en_r;
	logic ord_r;
	logic [3:0] thr_r;
	logic [21:0] vt_r;
	logic [7:0] clid_r;
	logic [3:0] clpri_r;
	logic [7:0] win_id;
	logic [3:0] win_prio;
	logic cap_wr;
	logic cap_go;
	logic [31:0] csr_rd_nxt;
	logic [31:0] mm_rd_nxt;
	logic [31:0] hap_w;

	// Enable-word decode, shared by read and write paths
	function automatic logic en_hit(input logic [14:0] a);
		en_hit = (a[14:10] == PTC_MM_EN_BASE[14:10]) && (a[9:2] != 8'h00)
			&& (a[1:0] == 2'b00);
	endfunction

	// Field move between core view and internal standard order
	function automatic logic [3:0] ord_map(input logic rev,
		input logic [3:0] v);
		ord_map = rev ? ~v : v;
	endfunction

	// CSR addresses owned here
	always_comb
	begin
		case (i_csr_addr)
			PTC_CSR_VT, PTC_CSR_THR, PTC_CSR_CLPRI,
			PTC_CSR_HAP: o_csr_hit = 1'b1;
			PTC_CSR_CAP: o_csr_hit = !FAST_REDIRECT;
			default: o_csr_hit = 1'b0;
		endcase
	end

	// Per-source enable bits
	genvar g;
	generate
		for (g = 1; g <= NSRC; g++)
		begin : g_en
			logic bit_r;
			always_ff @(posedge i_clk_sys or negedge i_rst_b)
			begin
				if (!i_rst_b)
					bit_r <= PTC_RST_EN;
				else if (i_mm_wr && en_hit(i_mm_addr)
					&& i_mm_addr[9:2] == 8'(g))
					bit_r <= i_mm_wdata[PTC_EN_BIT];
			end
			assign en_r[g] = bit_r;
		end
	endgenerate
	assign en_r[0] = 1'b0;
	assign o_src_enable = en_r;
	assign o_prio_reversed = ord_r;

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ord_r <= PTC_RST_ORD;
		else if (i_mm_wr && i_mm_addr == PTC_MM_CFG)
			ord_r <= i_mm_wdata[PTC_CFG_ORD_BIT];
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			thr_r <= PTC_RST_THR;
		else if (i_csr_wr && i_csr_addr == PTC_CSR_THR)
			thr_r <= ord_map(ord_r, i_csr_wdata[3:0]);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			vt_r <= PTC_RST_VT;
		else if (i_csr_wr && i_csr_addr == PTC_CSR_VT)
			vt_r <= i_csr_wdata[31:PTC_VT_BASE_LSB];
	end

	// Capture start: firmware trigger or hardware in fast builds
	// any written value triggers
	assign cap_wr = i_csr_wr && i_csr_addr == PTC_CSR_CAP && !FAST_REDIRECT;
	assign cap_go = FAST_REDIRECT ? i_hw_capture : cap_wr;

	// handler pointer built from the live base
	assign hap_w = {vt_r, clid_r, 2'b00};

	// claimed ID and level taken together
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			clid_r <= PTC_RST_CLID;
		else if (cap_go)
			clid_r <= win_id;
	end

	// claimed level, capture wins over a firmware write
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			clpri_r <= PTC_RST_CLPRI;
		else if (cap_go)
			clpri_r <= win_prio;
		else if (i_csr_wr && i_csr_addr == PTC_CSR_CLPRI)
			clpri_r <= ord_map(ord_r, i_csr_wdata[3:0]);
	end

	// Winner evaluation
	ptc_win_sel #(
		.NSRC(NSRC),
		.PRIO_W(PTC_PRIO_W),
		.ID_W(PTC_ID_W)
	) u_win (
		.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b),
		.i_en(en_r),
		.i_pend(i_src_pending),
		.i_prio(i_src_prio),
		.o_win_id(win_id),
		.o_win_prio(win_prio)
	);

	// notify only strictly above threshold; 15 masks all
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_ext_int <= 1'b0;
		else
			o_ext_int <= (win_id != 8'h00) && (win_prio > thr_r);
	end

	// CSR read mux
	always_comb
	begin
		csr_rd_nxt = 32'h0;
		case (i_csr_addr)
			PTC_CSR_VT: csr_rd_nxt = {vt_r, 10'h000};
			PTC_CSR_THR: csr_rd_nxt = {28'h0, ord_map(ord_r, thr_r)};
			PTC_CSR_CLPRI: csr_rd_nxt = {28'h0, ord_map(ord_r, clpri_r)};
			// live base, claimed ID, low bits zero
			PTC_CSR_HAP: csr_rd_nxt = hap_w;
			default: csr_rd_nxt = 32'h0;
		endcase
	end

	// Registered CSR read data
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_csr_rdata <= 32'h0;
		else if (i_csr_rd)
			o_csr_rdata <= csr_rd_nxt;
	end

	// Memory-mapped read mux; unmapped offsets read zero
	always_comb
	begin
		mm_rd_nxt = 32'h0;
		if (i_mm_addr == PTC_MM_CFG)
			mm_rd_nxt = {31'h0, ord_r};
		else if (en_hit(i_mm_addr))
			mm_rd_nxt = {31'h0, en_r[i_mm_addr[9:2]]};
	end

	// Registered memory-mapped read data
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_mm_rdata <= 32'h0;
		else if (i_mm_rd)
			o_mm_rdata <= mm_rd_nxt;
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);

	AST_EN_UPPER_ZERO: assert property (
		$past(i_mm_rd) && $past(en_hit(i_mm_addr)) |-> o_mm_rdata[31:1] == '0)
		else $error("enable word upper bits not zero");
	AST_NOTIFY_ABOVE: assert property (
		o_ext_int |-> $past(win_prio) > $past(thr_r) && $past(win_id) != 0)
		else $error("notification at or below threshold");
	AST_THR15_MASKS: assert property (
		thr_r == 4'hf ##1 thr_r == 4'hf |-> !o_ext_int)
		else $error("threshold 15 did not mask");
	AST_REV_WRITE15: assert property (
		i_csr_wr && i_csr_addr == PTC_CSR_THR && ord_r
		&& i_csr_wdata[3:0] == 4'hf |=> thr_r == 4'h0)
		else $error("reversed threshold 15 not stored as mask-none");
	AST_THR_READ: assert property (
		i_csr_rd && i_csr_addr == PTC_CSR_THR |=>
		o_csr_rdata == {28'h0, $past(ord_r) ? ~$past(thr_r) : $past(thr_r)})
		else $error("threshold read path wrong");
	AST_VT_LOW_ZERO: assert property (
		$past(i_csr_rd) && $past(i_csr_addr) == PTC_CSR_VT
		|-> o_csr_rdata[9:0] == 10'h0)
		else $error("vector base low bits not zero");
	AST_HAP_FORM: assert property (
		i_csr_rd && i_csr_addr == PTC_CSR_HAP
		|=> o_csr_rdata == {$past(vt_r), $past(clid_r), 2'b00})
		else $error("handler pointer wrongly formed");
	AST_CAPTURE_PAIR: assert property (
		cap_go |=> clid_r == $past(win_id) && clpri_r == $past(win_prio))
		else $error("capture pair not latched");
	AST_CAP_READ_ZERO: assert property (
		i_csr_rd && i_csr_addr == PTC_CSR_CAP |=> o_csr_rdata == 32'h0)
		else $error("capture trigger read not zero");
	AST_FAST_NO_TRIGGER: assert property (
		FAST_REDIRECT && i_csr_addr == PTC_CSR_CAP |-> !o_csr_hit)
		else $error("trigger present with fast redirect");
	AST_THR_STORE: assert property (
		i_csr_wr && i_csr_addr == PTC_CSR_THR && !ord_r
		|=> thr_r == $past(i_csr_wdata[3:0]))
		else $error("standard threshold not stored as written");
	AST_EN_WRITE: assert property (
		i_mm_wr && en_hit(i_mm_addr)
		|=> o_src_enable[$past(i_mm_addr[9:2])] == $past(i_mm_wdata[0]))
		else $error("enable write not applied");
	AST_HAP_LIVE_BASE: assert property (
		i_csr_wr && i_csr_addr == PTC_CSR_VT
		|=> hap_w[31:10] == $past(i_csr_wdata[31:10]))
		else $error("handler pointer base not live");
	AST_ORDER_OUT: assert property (
		i_mm_wr && i_mm_addr == PTC_MM_CFG |=> o_prio_reversed == $past(i_mm_wdata[0]))
		else $error("order bit not taken");
	AST_CLPRI_WRITE: assert property (
		i_csr_wr && i_csr_addr == PTC_CSR_CLPRI && !cap_go
		|=> clpri_r == ($past(ord_r) ? ~$past(i_csr_wdata[3:0])
		: $past(i_csr_wdata[3:0])))
		else $error("claimed level write path wrong");
	AST_NOTIFY_NO_WINNER: assert property (
		win_id == 8'h00 |=> !o_ext_int)
		else $error("notification without a winner");

	COV_CAPTURE: cover property (cap_go && win_id != 0);
	COV_NOTIFY: cover property (!o_ext_int ##1 o_ext_int);
	COV_REV_READ: cover property (ord_r && i_csr_rd
		&& i_csr_addr == PTC_CSR_THR);
	COV_HW_CAPTURE: cover property (FAST_REDIRECT && cap_go);
	COV_MASK_ALL: cover property (win_id != 0 && thr_r == 4'hf);
endmodule

// ==== design/ptc_pkg.sv ====
// Package with the addresses, field layouts and reset values of the target
package ptc_pkg;
	// Sizes
	localparam int PTC_NSRC = 255;
	localparam int PTC_PRIO_W = 4;
	localparam int PTC_ID_W = 8;
	// CSR addresses
	localparam logic [11:0] PTC_CSR_VT = 12'hbc8;
	localparam logic [11:0] PTC_CSR_THR = 12'hbc9;
	localparam logic [11:0] PTC_CSR_CAP = 12'hbca;
	localparam logic [11:0] PTC_CSR_CLPRI = 12'hbcb;
	localparam logic [11:0] PTC_CSR_HAP = 12'hfc8;
	// Memory-mapped offsets inside the 32 KB window
	localparam logic [14:0] PTC_MM_CFG = 15'h3000;
	localparam logic [14:0] PTC_MM_EN_BASE = 15'h2000;
	// Field positions
	localparam int PTC_VT_BASE_LSB = 10;
	localparam int PTC_HAP_ID_LSB = 2;
	localparam int PTC_CFG_ORD_BIT = 0;
	localparam int PTC_EN_BIT = 0;
	// Reset values
	localparam logic [21:0] PTC_RST_VT = 22'h0;
	localparam logic [3:0] PTC_RST_THR = 4'h0;
	localparam logic [3:0] PTC_RST_CLPRI = 4'h0;
	localparam logic [7:0] PTC_RST_CLID = 8'h0;
	localparam logic PTC_RST_ORD = 1'b0;
	localparam logic PTC_RST_EN = 1'b0;
endpackage

// ==== design/ptc_win_sel.sv ====
// Winner selection: highest gated priority, lowest ID on ties, registered
module ptc_win_sel
	import ptc_pkg::*;
#(
	parameter int NSRC = PTC_NSRC,
	parameter int PRIO_W = PTC_PRIO_W,
	parameter int ID_W = PTC_ID_W
)
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Source state, bit 0 unused
	input wire logic [NSRC:0] i_en,
	input wire logic [NSRC:0] i_pend,
	input wire logic [(NSRC+1)*PRIO_W-1:0] i_prio,
	// Registered winner
	output logic [ID_W-1:0] o_win_id,
	output logic [PRIO_W-1:0] o_win_prio
);
	logic [ID_W-1:0] id_nxt;
	logic [PRIO_W-1:0] prio_nxt;

	// Scan upward; only a strictly higher level replaces, so lowest ID wins
	always_comb
	begin
		id_nxt = '0;
		prio_nxt = '0;
		for (int s = 1; s <= NSRC; s++)
		begin
			if (i_en[s] && i_pend[s] && i_prio[s*PRIO_W +: PRIO_W] > prio_nxt)
			begin
				id_nxt = ID_W'(s);
				prio_nxt = i_prio[s*PRIO_W +: PRIO_W];
			end
		end
	end

	// Winner register
	always_ff @(posedge i_clk_sys or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_win_id <= '0;
			o_win_prio <= '0;
		end
		else
		begin
			o_win_id <= id_nxt;
			o_win_prio <= prio_nxt;
		end
	end

	// Winner is always an enabled pending source
	AST_WIN_QUALIFIED: assert property (@(posedge i_clk_sys)
		disable iff (!i_rst_b)
		o_win_id != '0 |-> 1'(($past(i_en) & $past(i_pend)) >> o_win_id))
		else $error("winner is disabled or not pending");
endmodule

// ==== verif/ptc_core_model.sv ====
// Core model: CSR accesses and the firmware claim sequence
module ptc_core_model
	import ptc_pkg::*;
(
	// Clock and read data
	input wire logic i_clk_sys,
	input wire logic [31:0] i_rdata,
	// CSR requests
	output logic [11:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [31:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle bus at time zero
	initial
	begin
		o_addr = 12'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 32'h0;
	end
	// One write; data turned away after release
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge i_clk_sys);
		o_addr = a;
		o_wdata = d;
		o_wr = 1'b1;
		@(negedge i_clk_sys);
		o_wr = 1'b0;
		o_wdata = ~d;
		o_addr = ~a;
	endtask
	// One read; data taken a cycle later
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(negedge i_clk_sys);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_clk_sys);
		o_rd = 1'b0;
		o_addr = ~a;
		d = i_rdata;
	endtask
	// Address only, no strobe, for the decode flag
	task automatic look(input logic [11:0] a);
		@(negedge i_clk_sys);
		o_addr = a;
		@(posedge i_clk_sys);
	endtask
	task automatic claim(output logic [31:0] hap);
		wr(PTC_CSR_CAP, 32'h0);
		rd(PTC_CSR_HAP, hap);
	endtask
endmodule

// ==== verif/test_ptc_target.sv ====
// Self-checking bench of the interrupt target with a core model
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module test_ptc_target;
	timeunit 1ns;
	timeprecision 1ns;
	import ptc_pkg::*;
	logic clk, rst_b, c_wr, c_rd, hit, m_wr, m_rd, ext, rev, ord;
	logic hit_f, hw_cap;
	logic [31:0] c_rdat_f;
	logic [7:0] fid = 8'h0;
	logic [3:0] fpl = 4'h0;
	logic [11:0] c_addr;
	logic [14:0] m_addr;
	logic [31:0] c_wd, c_rdat, m_wd, m_rdat, d, r;
	logic [255:0] pend, en_o, en_m;
	logic [1023:0] prio;
	logic [21:0] vt_m;
	logic [7:0] id, s;
	logic [3:0] lv, thr;
	logic [31:0] seed = 32'h0000db32;
	logic [11:0] ca [5] = '{PTC_CSR_VT, PTC_CSR_THR, PTC_CSR_CAP,
		PTC_CSR_CLPRI, PTC_CSR_HAP};
	int bad_count, checks_done, cyc;
	ptc_target #(.NSRC(255), .FAST_REDIRECT(1'b0)) i_dut (.i_clk_sys(clk),
		.i_rst_b(rst_b), .i_csr_addr(c_addr), .i_csr_wr(c_wr),
		.i_csr_rd(c_rd), .i_csr_wdata(c_wd), .o_csr_hit(hit),
		.o_csr_rdata(c_rdat), .i_mm_addr(m_addr), .i_mm_wr(m_wr),
		.i_mm_rd(m_rd), .i_mm_wdata(m_wd), .o_mm_rdata(m_rdat),
		.i_src_pending(pend), .i_src_prio(prio), .i_hw_capture(1'b0),
		.o_ext_int(ext), .o_prio_reversed(rev), .o_src_enable(en_o));
	ptc_core_model i_core (.i_clk_sys(clk), .i_rdata(c_rdat),
		.o_addr(c_addr), .o_wr(c_wr), .o_rd(c_rd), .o_wdata(c_wd));
	// Second target built with fast redirect; capture comes from hw_cap
	ptc_target #(.NSRC(255), .FAST_REDIRECT(1'b1)) i_dut_fast (
		.i_clk_sys(clk), .i_rst_b(rst_b), .i_csr_addr(c_addr),
		.i_csr_wr(c_wr), .i_csr_rd(c_rd), .i_csr_wdata(c_wd),
		.o_csr_hit(hit_f), .o_csr_rdata(c_rdat_f), .i_mm_addr(m_addr),
		.i_mm_wr(m_wr), .i_mm_rd(m_rd), .i_mm_wdata(m_wd), .o_mm_rdata(),
		.i_src_pending(pend), .i_src_prio(prio), .i_hw_capture(hw_cap),
		.o_ext_int(), .o_prio_reversed(), .o_src_enable());
	// Xorshift source of stimulus
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected winner: top level, lowest ID on ties
	function automatic void win(output logic [7:0] w, output logic [3:0] l);
		w = 8'h0;
		l = 4'h0;
		for (int k = 1; k < 256; k++)
			if (en_m[k] && pend[k] && prio[k*4+:4] > l)
			begin
				w = k[7:0];
				l = prio[k*4+:4];
			end
	endfunction
	task automatic mw(input logic [14:0] a, input logic [31:0] v);
		@(negedge clk);
		m_addr = a;
		m_wd = v;
		m_wr = 1'b1;
		@(negedge clk);
		m_wr = 1'b0;
		m_wd = ~v;
	endtask
	task automatic mr(input logic [14:0] a, output logic [31:0] v);
		@(negedge clk);
		m_addr = a;
		m_rd = 1'b1;
		@(negedge clk);
		m_rd = 1'b0;
		v = m_rdat;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Hang guard
	initial
	begin
		forever @(posedge clk)
		begin
			cyc++;
			if (cyc == 20000)
			begin
				bad_count++;
				tally_and_finish();
			end
		end
	end
	// Scenarios
	initial
	begin
		{rst_b, hw_cap, m_wr, m_rd, m_addr, m_wd, pend, prio, en_m} = '0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		foreach (ca[i])
		begin
			i_core.look(ca[i]);
			`CHK(hit, 1'b1)
			`CHK(hit_f, 1'(ca[i] != PTC_CSR_CAP))
			i_core.rd(ca[i], d);
			`CHK(d, 32'h0)
			`CHK(c_rdat_f, 32'h0)
		end
		i_core.look(12'hbcc);
		`CHK(hit, 1'b0)
		mr(PTC_MM_CFG, d);
		`CHK(d, 32'h0)
		mr(15'h2004, d);
		`CHK(d, 32'h0)
		mw(15'h23fc, 32'hffffffff);
		mr(15'h23fc, d);
		`CHK(d, 32'h1)
		mw(15'h2000, 32'hffffffff);
		mr(15'h2000, d);
		`CHK(d, 32'h0)
		i_core.wr(PTC_CSR_CAP, 32'hffffffff);
		i_core.rd(PTC_CSR_CAP, d);
		`CHK(d, 32'h0)
		en_m[255] = 1'b1;
		$display("test reset and edges done");
		for (int n = 0; n < 48; n++)
		begin
			r = xs();
			ord = r[0];
			mw(PTC_MM_CFG, {31'h0, ord});
			`CHK(rev, ord)
			for (int j = 0; j < 12; j++)
			begin
				r = xs();
				s = (r[7:0] == 8'h0) ? 8'h1 : r[7:0];
				mw(15'h2000 + {5'h0, s, 2'b00}, r);
				en_m[s] = r[PTC_EN_BIT];
			end
			r = xs();
			i_core.wr(PTC_CSR_VT, r);
			vt_m = r[31:10];
			for (int j = 0; j < 32; j++)
			begin
				prio[j*32+:32] = xs();
				if (j < 8)
					pend[j*32+:32] = xs();
			end
			if (n >= 44)
			begin
				pend = 256'h8;
				prio[15:12] = 4'hf;
				en_m[3] = 1'b1;
				mw(15'h200c, 32'h1);
			end
			r = xs();
			thr = (n < 44) ? r[3:0] : (ord ? {3'h0, ~n[0]} : {3'h7, n[0]});
			i_core.wr(PTC_CSR_THR, {28'h0, thr});
			repeat (4) @(negedge clk);
			win(id, lv);
			`CHK(en_o, {en_m[255:1], 1'b0})
			`CHK(ext, 1'(lv > (ord ? ~thr : thr)))
			i_core.rd(PTC_CSR_THR, d);
			`CHK(d, {28'h0, thr})
			i_core.rd(PTC_CSR_VT, d);
			`CHK(d, {vt_m, 10'h0})
			if (n[0])
			begin
				hw_cap = 1'b1;
				@(negedge clk);
				hw_cap = 1'b0;
				fid = id;
				fpl = lv;
			end
			i_core.claim(d);
			`CHK(d, {vt_m, id, 2'b00})
			`CHK(c_rdat_f, {vt_m, fid, 2'b00})
			`CHK(32'(d[9:2]), 32'(id))
			i_core.rd(PTC_CSR_CLPRI, d);
			`CHK(d, {28'h0, ord ? ~lv : lv})
			`CHK(c_rdat_f, {28'h0, ord ? ~fpl : fpl})
			r = xs();
			i_core.wr(PTC_CSR_CLPRI, r);
			i_core.rd(PTC_CSR_CLPRI, d);
			`CHK(d, {28'h0, r[3:0]})
			fpl = ord ? ~r[3:0] : r[3:0];
		end
		$display("test random and threshold corners done");
		tally_and_finish();
	end
endmodule
